// File: hdl/rtusfh_crc16.sv
`timescale 1ns/10ps
module rtusfh_crc16
  import rtusfh_pkg::*;
(
  input  logic [15:0] i_crc,
  input  logic [7:0]  i_byte,
  output logic [15:0] o_crc
);

  // The byte is folded in least significant bit first, reflected polynomial.
  always_comb
  begin
    o_crc = i_crc ^ {8'h00, i_byte};
    for (int b = 0; b < 8; b++)
    begin
      if (o_crc[0])
      begin
        o_crc = (o_crc >> 1) ^ CRC_POLY;
      end
      else
      begin
        o_crc = o_crc >> 1;
      end
    end
  end

endmodule

// File: hdl/rtusfh_fifo.sv
`timescale 1ns/10ps
module rtusfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  logic             i_sys_clk,
  input  logic             i_rst,
  input  logic [WIDTH-1:0] i_data,
  input  logic             i_valid,
  output logic             o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic             o_valid,
  input  logic             i_ready
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
      $error("FIFO depth must be a power of two of at least two.");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign o_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign o_valid = wr_ptr_reg != rd_ptr_reg;
  assign o_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
    else $error("FIFO holds more words than its depth.");

endmodule

// File: hdl/rtusfh_pkg.sv
package rtusfh_pkg;

  localparam logic [7:0]  BCAST_ADDR      = 8'h00;
  localparam logic [7:0]  MAX_STATION     = 8'hf7;
  localparam logic [7:0]  FN_READ_HOLD    = 8'h03;
  localparam logic [7:0]  FN_WRITE_ONE    = 8'h06;
  localparam logic [7:0]  FN_DIAG         = 8'h08;
  localparam logic [7:0]  FN_WRITE_MANY   = 8'h10;
  localparam logic [7:0]  FN_ACCESS_LOG   = 8'h46;
  localparam logic [7:0]  EXC_FLAG        = 8'h80;
  localparam logic [7:0]  EXC_ILLEGAL_FN  = 8'h01;
  localparam logic [15:0] CRC_INIT        = 16'hffff;
  localparam logic [15:0] CRC_POLY        = 16'ha001;
  localparam logic [7:0]  STATION_RST     = 8'h01;
  localparam int          CLK_HZ          = 20000000;
  localparam int          BAUD_DEFAULT    = 19200;
  localparam int          BITS_PER_CHAR   = 11;
  localparam int          GAP_TENTHS_CHAR = 35;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          MAX_FRAME       = 256;

  typedef enum logic [2:0] {RTUS_IDLE, RTUS_RECV, RTUS_DISCARD, RTUS_EXEC, RTUS_SEND}
    rtusfh_state_t;

endpackage

// File: hdl/rtusfh_top.sv
`timescale 1ns/10ps
module rtusfh_top
  import rtusfh_pkg::*;
#(
  parameter int BAUD = BAUD_DEFAULT
) (
  input  logic       i_sys_clk,
  input  logic       i_rst,
  input  logic [7:0] i_station,
  input  logic [7:0] i_rx_data,
  input  logic       i_rx_valid,
  input  logic       i_rx_error,
  output logic [7:0] o_tx_data,
  output logic       o_tx_valid,
  input  logic       i_tx_ready,
  output logic       o_req_valid,
  output logic       o_req_broadcast,
  output logic [7:0] o_req_func,
  output logic [7:0] o_req_len,
  output logic       o_busy,
  output logic       o_crc_fail
);

  // Gap of 3.5 characters, counted in system clocks and rounded up.
  localparam int GAP_CYCLES = int'((longint'(CLK_HZ) * BITS_PER_CHAR * GAP_TENTHS_CHAR
                              + longint'(BAUD) * 10 - 1) / (longint'(BAUD) * 10));
  localparam int GW = $clog2(GAP_CYCLES + 1);

  initial
  begin
    if (BAUD < 300 || GAP_CYCLES < 1)
    begin
      $error("Baud rate out of range for the gap timer.");
    end
  end

  function automatic logic fn_supported(input logic [7:0] fn);
    return fn == FN_READ_HOLD || fn == FN_WRITE_ONE || fn == FN_DIAG ||
           fn == FN_WRITE_MANY || fn == FN_ACCESS_LOG;
  endfunction

  function automatic logic fn_bcast_ok(input logic [7:0] fn);
    return fn == FN_WRITE_ONE || fn == FN_WRITE_MANY;
  endfunction

  rtusfh_state_t    state_reg;
  logic [GW-1:0]    gap_cnt_reg;
  logic             gap_done;
  logic [7:0]       rx_addr_reg;
  logic [7:0]       rx_func_reg;
  logic [8:0]       rx_cnt_reg;
  logic [15:0]      crc_reg;
  logic [15:0]      crc_next;
  logic [7:0]       hist0_reg;
  logic [7:0]       hist1_reg;
  logic             err_reg;
  logic [15:0]      hist_crc0_reg;
  logic [15:0]      hist_crc1_reg;
  logic [15:0]      tx_crc_reg;
  logic [15:0]      tx_crc_next;
  logic [2:0]       tx_idx_reg;
  logic [7:0]       tx_byte;
  logic             tx_last;
  logic             fifo_ready;
  logic             fifo_push;
  logic             frame_ok;
  logic             addr_hit;
  logic             is_bcast;
  logic             exc_reply;
  logic             send_reply;

  assign gap_done = gap_cnt_reg == GW'(GAP_CYCLES);

  // Idle timer: restarts on every received character.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      gap_cnt_reg <= GW'(GAP_CYCLES);
    end
    else if (i_rx_valid || i_rx_error)
    begin
      gap_cnt_reg <= '0;
    end
    else if (!gap_done)
    begin
      gap_cnt_reg <= gap_cnt_reg + 1'b1;
    end
  end

  rtusfh_crc16 u_rx_crc (
    .i_crc  (crc_reg),
    .i_byte (i_rx_data),
    .o_crc  (crc_next)
  );

  assign is_bcast  = rx_addr_reg == BCAST_ADDR;
  assign addr_hit  = is_bcast || rx_addr_reg == i_station;
  // CRC over all bytes but the last two must equal the received pair, low first.
  assign frame_ok  = !err_reg && rx_cnt_reg >= 9'd4 &&
                     hist_crc1_reg == {hist0_reg, hist1_reg};
  assign exc_reply = !fn_supported(rx_func_reg);
  // Broadcast never answers; refused broadcast codes are silently dropped.
  assign send_reply = frame_ok && addr_hit && !is_bcast;

  // Receive capture: history of CRC values lets the trailing two bytes be excluded.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rx_cnt_reg    <= '0;
      crc_reg       <= CRC_INIT;
      hist_crc0_reg <= CRC_INIT;
      hist_crc1_reg <= CRC_INIT;
      hist0_reg     <= '0;
      hist1_reg     <= '0;
      rx_addr_reg   <= '0;
      rx_func_reg   <= '0;
      err_reg       <= 1'b0;
    end
    else if (state_reg == RTUS_IDLE && gap_done && !i_rx_valid && !i_rx_error)
    begin
      rx_cnt_reg    <= '0;
      crc_reg       <= CRC_INIT;
      hist_crc0_reg <= CRC_INIT;
      hist_crc1_reg <= CRC_INIT;
      err_reg       <= 1'b0;
    end
    else if ((state_reg == RTUS_IDLE || state_reg == RTUS_RECV) && i_rx_valid)
    begin
      crc_reg       <= crc_next;
      hist_crc0_reg <= crc_reg;
      hist_crc1_reg <= hist_crc0_reg;
      hist1_reg     <= hist0_reg;
      hist0_reg     <= i_rx_data;
      if (rx_cnt_reg != 9'(MAX_FRAME))
      begin
        rx_cnt_reg <= rx_cnt_reg + 1'b1;
      end
      else
      begin
        err_reg <= 1'b1;
      end
      if (rx_cnt_reg == 9'd0)
      begin
        rx_addr_reg <= i_rx_data;
      end
      if (rx_cnt_reg == 9'd1)
      begin
        rx_func_reg <= i_rx_data;
      end
    end
    else if ((state_reg == RTUS_IDLE || state_reg == RTUS_RECV) && i_rx_error)
    begin
      err_reg <= 1'b1;
    end
  end

  // Frame sequencing.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_reg <= RTUS_IDLE;
    end
    else
    begin
      case (state_reg)
        RTUS_IDLE:
        begin
          if (i_rx_valid || i_rx_error)
          begin
            state_reg <= RTUS_RECV;
          end
        end
        RTUS_RECV:
        begin
          if (gap_done)
          begin
            state_reg <= RTUS_EXEC;
          end
        end
        RTUS_EXEC:
        begin
          state_reg <= send_reply ? RTUS_SEND : RTUS_IDLE;
        end
        RTUS_SEND:
        begin
          if (fifo_push && tx_last)
          begin
            state_reg <= RTUS_DISCARD;
          end
        end
        default:
        begin
          state_reg <= RTUS_IDLE;
        end
      endcase
    end
  end

  // Request handed to the register engine; data fields are outside this block.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_req_valid     <= 1'b0;
      o_req_broadcast <= 1'b0;
      o_req_func      <= '0;
      o_req_len       <= '0;
      o_crc_fail      <= 1'b0;
    end
    else
    begin
      o_req_valid <= state_reg == RTUS_EXEC && frame_ok && addr_hit &&
                     fn_supported(rx_func_reg) &&
                     (!is_bcast || fn_bcast_ok(rx_func_reg));
      o_req_broadcast <= is_bcast;
      o_req_func      <= rx_func_reg;
      o_req_len       <= 8'(rx_cnt_reg - 9'd4);
      o_crc_fail      <= state_reg == RTUS_EXEC && !frame_ok;
    end
  end

  // Reply header: address, function (or exception), code byte, then CRC low, high.
  always_comb
  begin
    tx_last = 1'b0;
    case (tx_idx_reg)
      3'd0:    tx_byte = rx_addr_reg;
      3'd1:    tx_byte = exc_reply ? (rx_func_reg | EXC_FLAG) : rx_func_reg;
      3'd2:    tx_byte = exc_reply ? EXC_ILLEGAL_FN : 8'h00;
      3'd3:    tx_byte = tx_crc_reg[7:0];
      default:
      begin
        tx_byte = tx_crc_reg[15:8];
        tx_last = 1'b1;
      end
    endcase
  end

  rtusfh_crc16 u_tx_crc (
    .i_crc  (tx_crc_reg),
    .i_byte (tx_byte),
    .o_crc  (tx_crc_next)
  );

  assign fifo_push = state_reg == RTUS_SEND && fifo_ready;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || state_reg != RTUS_SEND)
    begin
      tx_idx_reg <= '0;
      tx_crc_reg <= CRC_INIT;
    end
    else if (fifo_push)
    begin
      tx_idx_reg <= (tx_idx_reg == 3'd2) ? 3'd3 : tx_idx_reg + 1'b1;
      if (tx_idx_reg < 3'd3)
      begin
        tx_crc_reg <= tx_crc_next;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_busy <= 1'b0;
    end
    else
    begin
      o_busy <= state_reg != RTUS_IDLE;
    end
  end

  logic [7:0] fifo_data;
  logic       fifo_valid;

  rtusfh_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_data    (tx_byte),
    .i_valid   (fifo_push),
    .o_ready   (fifo_ready),
    .o_data    (fifo_data),
    .o_valid   (fifo_valid),
    .i_ready   (!o_tx_valid || i_tx_ready)
  );

  // Output stage registered so the transmit port comes straight from flops.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= '0;
    end
    else if (!o_tx_valid || i_tx_ready)
    begin
      o_tx_valid <= fifo_valid;
      o_tx_data  <= fifo_data;
    end
  end

  sequence exec_bad_s;
    state_reg == RTUS_EXEC && !send_reply;
  endsequence

  no_reply_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    exec_bad_s |=> state_reg == RTUS_IDLE)
    else $error("Reply started for a rejected frame.");

  bcast_silent_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_EXEC && is_bcast |=> state_reg != RTUS_SEND)
    else $error("Broadcast frame was answered.");

  addr_echo_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_SEND && tx_idx_reg == 3'd0 |-> tx_byte == rx_addr_reg)
    else $error("Reply address differs from query.");

  exc_func_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_SEND && tx_idx_reg == 3'd1 && exc_reply
      |-> tx_byte == (rx_func_reg | 8'h80))
    else $error("Exception function byte wrong.");

  norm_func_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_SEND && tx_idx_reg == 3'd1 && !exc_reply
      |-> tx_byte == rx_func_reg)
    else $error("Normal function byte altered.");

  read_bcast_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_EXEC && is_bcast && rx_func_reg == 8'h03 |=> !o_req_valid)
    else $error("Broadcast read executed.");

  unsup_exec_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_EXEC && exc_reply |=> !o_req_valid)
    else $error("Unsupported function executed.");

  gap_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_reg == RTUS_RECV && i_rx_valid |=> state_reg == RTUS_RECV)
    else $error("Frame closed without an idle gap.");

  crc_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fifo_push && tx_idx_reg == 3'd3 |=> tx_byte == tx_crc_reg[15:8])
    else $error("CRC bytes out of order.");

endmodule

// File: tb/rtu_slave_frame_handler_test.sv
`timescale 1ns/10ps
module rtu_slave_frame_handler_test;
  import rtusfh_pkg::*;
  localparam int BAUD = 2000000;
  localparam longint GL = longint'(CLK_HZ) * BITS_PER_CHAR * GAP_TENTHS_CHAR / 10;
  localparam int GAP = int'((GL + BAUD - 1) / BAUD);

  logic        i_sys_clk;
  logic        i_rst;
  logic [7:0]  station;
  logic        stall;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_error;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        req_valid;
  logic        req_bcast;
  logic [7:0]  req_func;
  logic [7:0]  req_len;
  logic        crc_fail;
  logic        busy;
  logic [16:0] req_q[$];
  int          fail_n;
  int          err_total;
  int          n_compared;
  logic [31:0] seed;
  logic [7:0]  fn_tab[8];

  rtusfh_top #(.BAUD(BAUD)) rtusfh_top_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_station(station), .i_rx_data(rx_data),
    .i_rx_valid(rx_valid), .i_rx_error(rx_error), .o_tx_data(tx_data),
    .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_req_valid(req_valid),
    .o_req_broadcast(req_bcast), .o_req_func(req_func), .o_req_len(req_len),
    .o_busy(busy), .o_crc_fail(crc_fail));

  rtusfh_master_model master_i (
    .i_sys_clk(i_sys_clk), .i_stall(stall), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
    .o_rx_error(rx_error));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  always @(negedge i_sys_clk)
    stall <= (rnd() % 4) == 0;

  always @(posedge i_sys_clk)
  begin
    if (req_valid)
      req_q.push_back({req_bcast, req_func, req_len});
    if (crc_fail)
      fail_n++;
  end

  initial
  begin
    #(50ns * 60000);
    err_total++;
    final_report();
  end

  initial
  begin
    logic [7:0]  fr[$];
    logic [7:0]  ex[$];
    logic [7:0]  a;
    logic [7:0]  f;
    logic [15:0] c;
    int          kind;
    int          n;
    logic        sup;
    logic        want_req;
    logic        bc;
    seed = 32'h6e534ede;
    fn_tab = '{FN_READ_HOLD, FN_WRITE_ONE, FN_DIAG, FN_WRITE_MANY, FN_ACCESS_LOG,
               8'h01, 8'h07, 8'hff};
    err_total = 0;
    n_compared = 0;
    fail_n = 0;
    station = STATION_RST;
    i_rst = 1'b1;
    repeat (12) @(negedge i_sys_clk);
    i_rst = 1'b0;
    for (int it = 0; it < 72; it++)
    begin
      station = 8'(1 + rnd() % 247);
      f = fn_tab[it % 8];
      kind = (it / 8) % 9;
      n = rnd() % 5;
      sup = (it % 8) < 5;
      bc = (kind == 3 || kind == 4);
      a = bc ? BCAST_ADDR : (kind == 5 ? ((station == 8'hf7) ? 8'h01 : station + 8'h01)
                                       : station);
      fr = {a, f};
      repeat (n) fr.push_back(8'(rnd()));
      c = crc16(fr);
      fr.push_back(c[7:0]);
      fr.push_back(c[15:8]);
      if (kind == 6)
        fr[fr.size() - 2] = ~fr[fr.size() - 2];
      if (kind == 8)
        fr = fr[0:1];
      ex = {};
      want_req = 1'b0;
      if (kind < 3 || kind == 4 && it[0])
      begin
        bc = 1'b0;
        a = station;
        fr[0] = a;
        c = crc16(fr[0:fr.size() - 3]);
        fr[fr.size() - 2] = c[7:0];
        fr[fr.size() - 1] = c[15:8];
      end
      if (!bc && a == station && kind < 5)
      begin
        ex = {a, sup ? f : (f | EXC_FLAG), sup ? 8'h00 : EXC_ILLEGAL_FN};
        c = crc16(ex);
        ex.push_back(c[7:0]);
        ex.push_back(c[15:8]);
        want_req = sup;
      end
      if (bc && kind < 5)
        want_req = (f == FN_WRITE_ONE || f == FN_WRITE_MANY);
      master_i.got = {};
      req_q = {};
      fail_n = 0;
      foreach (fr[i])
        master_i.send(fr[i], 1'b0);
      if (kind == 7)
        master_i.send(8'h00, 1'b1);
      chk(17'(busy), 17'd1);
      repeat (GAP + 80) @(negedge i_sys_clk);
      chk(17'(busy), 17'd0);
      chk(17'(master_i.got.size()), 17'(ex.size()));
      foreach (ex[i])
        if (i < master_i.got.size())
          chk({9'h000, master_i.got[i]}, {9'h000, ex[i]});
      chk(17'(req_q.size()), {16'h0000, want_req});
      if (want_req && req_q.size() > 0)
        chk(req_q[0], {bc, f, 8'(n)});
      chk(17'(fail_n), 17'(kind >= 6));
    end
    final_report();
  end
endmodule

// File: tb/rtusfh_master_model.sv
`timescale 1ns/10ps
module rtusfh_master_model
  import rtusfh_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_stall,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_error
);
  logic [7:0] got[$];

  initial
  begin
    o_rx_data  = 8'h00;
    o_rx_valid = 1'b0;
    o_rx_error = 1'b0;
    o_tx_ready = 1'b0;
  end

  // A slow master holds ready low now and then, as a busy receiver would.
  always @(negedge i_sys_clk)
    o_tx_ready <= !i_stall;

  always @(posedge i_sys_clk)
    if (i_tx_valid && o_tx_ready)
      got.push_back(i_tx_data);

  // One character, or a receive error in its place, then the line idles.
  task automatic send(input logic [7:0] b, input logic err);
    @(negedge i_sys_clk);
    o_rx_data  <= b;
    o_rx_valid <= !err;
    o_rx_error <= err;
    @(negedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_error <= 1'b0;
    // Stale data must not look valid between characters.
    o_rx_data  <= ~b;
    @(negedge i_sys_clk);
  endtask
endmodule
